// >>> rtl/pig_gpio.sv
// pin control, readback and peripheral override of six ports, edge interrupts of ports p and j
// assumes pins asynchronous to core_clk_in and a single-cycle strobe register port
//
// Overview of operation
// - direction bit 0 makes the pin input, 1 makes it output
// - pin readback passes two synchroniser flops, lagging up to two cycles
// - reduced-drive bit lowers drive only while the pin is an output
// - every pin is gpio or carries a peripheral signal
// - registers other than the read-only input register always writable; settings act only when pin usage allows
// - pull-up is off whenever the pin is a push-pull output
// - data register value drives the pin only as gpio output
// - data read returns synchronised pin level where direction is 0
// - data read returns stored value where direction is 1
// - input register is read-only and always returns the pin level
// - a peripheral owning a pin overrides its direction bit
// - pull enable acts only for inputs or wired-or outputs
// - polarity picks up or down for inputs; wired-or allows only up
// - routing register moves pulse-width channels from port p to port t
// - after reset port t pins are inputs with no pull
// - after reset ports s and m are inputs with pull-ups on
// - analog port pin is input with direction clear, output when set
// - converter-side readback needs direction clear and digital enable set
// - ports p and j raise separate edge interrupts, flag, enable, i mask
// - enabled edges on p and j wake from stop without the clock
`timescale 1ns/1ps
`include "pig_regs.svh"

module pig_gpio
  import pig_pkg::*;
(
  // clock, reset, enable
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // pins, bit 8*port+n, ports t s m p ad j
  input wire logic [47:0] pin_in,
  output logic [47:0] pin_out,
  output logic [47:0] pin_oe_n_out,
  output logic [47:0] pull_up_out,
  output logic [47:0] pull_down_out,
  output logic [47:0] reduced_drive_out,
  // peripheral side
  input wire logic [47:0] periph_own_in,
  input wire logic [47:0] periph_dir_in,
  input wire logic [47:0] periph_data_in,
  output logic [47:0] periph_pin_out,
  input wire logic [7:0] pwm_en_in,
  input wire logic [7:0] pwm_data_in,
  // converter side
  input wire logic [7:0] converter_digital_input_enable_in,
  output logic [7:0] converter_side_port_data_out,
  // interrupts and wake
  input wire logic cpu_i_mask_in,
  output logic port_p_irq_out,
  output logic port_j_irq_out,
  output logic stop_wake_out
);

  pig_byte_t data_r [`PIG_NPORTS];
  pig_byte_t dir_r [`PIG_NPORTS];
  pig_byte_t rdr_r [`PIG_NPORTS];
  pig_byte_t pe_r [`PIG_NPORTS];
  pig_byte_t ps_r [`PIG_NPORTS];
  pig_byte_t aux_r [`PIG_NPORTS];
  pig_byte_t flag_r [`PIG_NPORTS];
  pig_byte_t in_b [`PIG_NPORTS];
  pig_byte_t edge_b [`PIG_NPORTS];
  pig_byte_t wake_b [`PIG_NPORTS];
  pig_byte_t route_r;
  pig_byte_t rdata_nxt;
  logic [47:0] sync1_r;
  logic [47:0] sync2_r;
  logic [47:0] sync3_r;
  logic [47:0] pin_nxt;
  logic [47:0] oe_n_nxt;
  logic [47:0] pu_nxt;
  logic [47:0] pd_nxt;
  logic [47:0] rd_nxt;

  // implemented bits of each port
  function automatic pig_byte_t pig_mask(input int p);
    case (p)
      PIG_T: pig_mask = `PIG_MASK_T;
      PIG_S: pig_mask = `PIG_MASK_S;
      PIG_M: pig_mask = `PIG_MASK_M;
      PIG_P: pig_mask = `PIG_MASK_P;
      PIG_AD: pig_mask = `PIG_MASK_AD;
      PIG_J: pig_mask = `PIG_MASK_J;
      default: pig_mask = 8'h00;
    endcase
  endfunction

  // bits that carry an edge interrupt
  function automatic pig_byte_t pig_irq_mask(input int p);
    if (p == PIG_P) begin
      pig_irq_mask = `PIG_MASK_P;
    end else if (p == PIG_J) begin
      pig_irq_mask = `PIG_MASK_J;
    end else begin
      pig_irq_mask = 8'h00;
    end
  endfunction

  // port select from the upper address bits
  function automatic logic pig_hit(input logic [7:0] a, input int p);
    pig_hit = (a[7:6] == 2'h0) && (int'(a[5:3]) == p);
  endfunction

  // two-flop synchroniser plus one history stage for edges
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else if (ce_in) begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  assign periph_pin_out = sync2_r;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      route_r <= 8'h00;
    end else if (ce_in && reg_wr_in && reg_addr_in == `PIG_ROUTE_ADDR) begin
      route_r <= reg_wdata_in;
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < `PIG_NPORTS; gp++) begin : g_port
      localparam pig_byte_t MSK = pig_mask(gp);
      localparam pig_byte_t IMSK = pig_irq_mask(gp);
      localparam pig_byte_t PE_RST = (gp == PIG_S) ? `PIG_PE_RST_S :
                                     (gp == PIG_M) ? `PIG_PE_RST_M : 8'h00;
      logic wr_hit;

      assign in_b[gp] = sync2_r[gp*8 +: 8] & MSK;
      assign wr_hit = ce_in && reg_wr_in && pig_hit(reg_addr_in, gp);
      // falling edge with polarity 0, rising with polarity 1
      assign edge_b[gp] = IMSK & ((ps_r[gp] & sync2_r[gp*8 +: 8] & ~sync3_r[gp*8 +: 8]) |
                                  (~ps_r[gp] & ~sync2_r[gp*8 +: 8] & sync3_r[gp*8 +: 8]));
      // unclocked path from the raw pin so stop mode can be left
      assign wake_b[gp] = IMSK & aux_r[gp] &
                          ((ps_r[gp] & pin_in[gp*8 +: 8] & ~sync2_r[gp*8 +: 8]) |
                           (~ps_r[gp] & ~pin_in[gp*8 +: 8] & sync2_r[gp*8 +: 8]));

      always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
          data_r[gp] <= 8'h00;
          dir_r[gp] <= 8'h00;
          rdr_r[gp] <= 8'h00;
          pe_r[gp] <= PE_RST;
          ps_r[gp] <= 8'h00;
          aux_r[gp] <= 8'h00;
        end else if (wr_hit) begin
          case (reg_addr_in[2:0])
            `PIG_OFS_DATA: data_r[gp] <= reg_wdata_in & MSK;
            `PIG_OFS_DIR: dir_r[gp] <= reg_wdata_in & MSK;
            `PIG_OFS_RDR: rdr_r[gp] <= reg_wdata_in & MSK;
            `PIG_OFS_PE: pe_r[gp] <= reg_wdata_in & MSK;
            `PIG_OFS_PS: ps_r[gp] <= reg_wdata_in & MSK;
            `PIG_OFS_AUX: aux_r[gp] <= reg_wdata_in & MSK;
            default: ;
          endcase
        end
      end

      // set wins over a write-one clear in the same cycle
      always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
          flag_r[gp] <= 8'h00;
        end else if (ce_in) begin
          if (wr_hit && reg_addr_in[2:0] == `PIG_OFS_FLAG) begin
            flag_r[gp] <= (flag_r[gp] & ~reg_wdata_in) | edge_b[gp];
          end else begin
            flag_r[gp] <= flag_r[gp] | edge_b[gp];
          end
        end
      end
    end
  endgenerate

  // per-pin drive, pull and strength decisions
  genvar gi;
  generate
    for (gi = 0; gi < `PIG_NPINS; gi++) begin : g_pin
      localparam int P = gi / 8;
      localparam int B = gi % 8;
      localparam pig_byte_t MSK = pig_mask(P);
      localparam logic IMPL = MSK[B];
      localparam logic WOM_OK = (P == PIG_S) || (P == PIG_M);
      logic pwm_own;
      logic own;
      logic oe;
      logic val;
      logic wom;
      logic pull;

      if (P == PIG_T) begin : g_t
        assign pwm_own = pwm_en_in[B] & route_r[B];
      end else if (P == PIG_P) begin : g_p
        assign pwm_own = pwm_en_in[B] & ~route_r[B];
      end else begin : g_o
        assign pwm_own = 1'b0;
      end

      assign own = periph_own_in[gi] | pwm_own;
      assign oe = pwm_own | (periph_own_in[gi] ? periph_dir_in[gi] : dir_r[P][B]);
      assign val = pwm_own ? pwm_data_in[B] :
                   (own ? periph_data_in[gi] : data_r[P][B]);
      assign wom = WOM_OK & aux_r[P][B];
      assign pull = pe_r[P][B] & (~oe | wom);
      assign pin_nxt[gi] = IMPL & val;
      // wired-or drives only the low level
      assign oe_n_nxt[gi] = ~(IMPL & oe & ~(wom & val));
      assign pu_nxt[gi] = IMPL & pull & (oe | ~ps_r[P][B]);
      assign pd_nxt[gi] = IMPL & pull & ~oe & ps_r[P][B];
      assign rd_nxt[gi] = IMPL & rdr_r[P][B] & oe;
    end
  endgenerate

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      pin_out <= '0;
      pin_oe_n_out <= '1;
      pull_up_out <= {8'h00, 8'h00, 8'h00, `PIG_PE_RST_M, `PIG_PE_RST_S, 8'h00};
      pull_down_out <= '0;
      reduced_drive_out <= '0;
    end else if (ce_in) begin
      pin_out <= pin_nxt;
      pin_oe_n_out <= oe_n_nxt;
      pull_up_out <= pu_nxt;
      pull_down_out <= pd_nxt;
      reduced_drive_out <= rd_nxt;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      converter_side_port_data_out <= 8'h00;
    end else if (ce_in) begin
      converter_side_port_data_out <= in_b[PIG_AD] & ~dir_r[PIG_AD] &
                                      converter_digital_input_enable_in;
    end
  end

  assign port_p_irq_out = ~cpu_i_mask_in & |(flag_r[PIG_P] & aux_r[PIG_P]);
  assign port_j_irq_out = ~cpu_i_mask_in & |(flag_r[PIG_J] & aux_r[PIG_J]);
  assign stop_wake_out = |wake_b[PIG_P] | |wake_b[PIG_J];

  // read mux, answered from a flop one cycle after the strobe
  always_comb begin
    int p;
    rdata_nxt = 8'h00;
    p = int'(reg_addr_in[5:3]);
    if (reg_addr_in == `PIG_ROUTE_ADDR) begin
      rdata_nxt = route_r;
    end else if (reg_addr_in[7:6] == 2'h0 && p < `PIG_NPORTS) begin
      case (reg_addr_in[2:0])
        `PIG_OFS_DATA: rdata_nxt = (dir_r[p] & data_r[p]) | (~dir_r[p] & in_b[p]);
        `PIG_OFS_INPUT: rdata_nxt = in_b[p];
        `PIG_OFS_DIR: rdata_nxt = dir_r[p];
        `PIG_OFS_RDR: rdata_nxt = rdr_r[p];
        `PIG_OFS_PE: rdata_nxt = pe_r[p];
        `PIG_OFS_PS: rdata_nxt = ps_r[p];
        `PIG_OFS_AUX: rdata_nxt = aux_r[p];
        `PIG_OFS_FLAG: rdata_nxt = flag_r[p];
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      reg_rdata_out <= 8'h00;
    end else if (ce_in) begin
      reg_rdata_out <= reg_rd_in ? rdata_nxt : 8'h00;
    end
  end

endmodule

// >>> rtl/pig_regs.svh
// register map, field masks, reset values and timing counts of the gpio block
// assumes one register per byte address, ports laid out eight bytes apart
`ifndef PIG_REGS_SVH
`define PIG_REGS_SVH
`define PIG_NPORTS 6
`define PIG_NPINS 48
`define PIG_OFS_DATA 3'h0
`define PIG_OFS_INPUT 3'h1
`define PIG_OFS_DIR 3'h2
`define PIG_OFS_RDR 3'h3
`define PIG_OFS_PE 3'h4
`define PIG_OFS_PS 3'h5
`define PIG_OFS_AUX 3'h6
`define PIG_OFS_FLAG 3'h7
`define PIG_ROUTE_ADDR 8'h30
`define PIG_J_DRIVE_ADDR 8'h2b
`define PIG_MASK_T 8'hff
`define PIG_MASK_S 8'h0f
`define PIG_MASK_M 8'h3f
`define PIG_MASK_P 8'hff
`define PIG_MASK_AD 8'hff
`define PIG_MASK_J 8'hc0
`define PIG_PE_RST_S 8'h0f
`define PIG_PE_RST_M 8'h3f
`define PIG_SYNC_LAG_CYC 2
`endif

// >>> rtl/pig_pkg.sv
// types shared by the gpio port block
// assumes the register map header is included by the design file
package pig_pkg;
  typedef logic [7:0] pig_byte_t;
  typedef enum {
    PIG_T,
    PIG_S,
    PIG_M,
    PIG_P,
    PIG_AD,
    PIG_J
  } pig_port_t;
endpackage

// >>> bench/pig_gpio_props.sv
// port-level assertions of the gpio port block
// assumes ce_in held high by the bench and bound to pig_gpio
`timescale 1ns/1ps
module pig_gpio_props (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // pins and interrupts
  input wire logic [47:0] pin_in,
  input wire logic [47:0] pin_oe_n_out,
  input wire logic [47:0] pull_up_out,
  input wire logic [47:0] pull_down_out,
  input wire logic [47:0] reduced_drive_out,
  input wire logic cpu_i_mask_in,
  input wire logic port_p_irq_out,
  input wire logic port_j_irq_out
);
  // push-pull ports: all but s and m
  localparam logic [47:0] PP = 48'hffffff0000ff;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in || !ce_in);
  a_read_idle_zero: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data not zero outside read");
  a_pushpull_no_pullup: assert property ((~pin_oe_n_out & pull_up_out & PP) == 48'h0)
    else $error("pull-up on push-pull output");
  a_output_no_pulldown: assert property ((~pin_oe_n_out & pull_down_out) == 48'h0)
    else $error("pull-down on driven pin");
  a_drive_only_out: assert property ((reduced_drive_out & pin_oe_n_out) == 48'h0)
    else $error("reduced drive on input pin");
  a_irq_masked_off: assert property (
    cpu_i_mask_in |-> !(port_p_irq_out || port_j_irq_out))
    else $error("irq while masked");
  a_input_read_pin: assert property (
    (reg_rd_in && reg_addr_in == 8'h19 && !$past(reset_in)
    && !$past(reset_in, 2) && $stable(pin_in[31:24])
    && $past(pin_in[31:24], 2) == pin_in[31:24])
    |=> reg_rdata_out == $past(pin_in[31:24]))
    else $error("input read differs from pin");
  a_reset_pull_state: assert property ($past(reset_in) |->
    pull_up_out == 48'h0000003f0f00 && pull_down_out == 48'h0)
    else $error("pull state after reset");
  a_reset_all_inputs: assert property ($past(reset_in) |->
    pin_oe_n_out == 48'hffffffffffff)
    else $error("pin driven after reset");
endmodule
bind pig_gpio pig_gpio_props pig_gpio_props_i (.core_clk_in(core_clk_in), .reset_in(reset_in),
  .ce_in(ce_in), .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .pin_in(pin_in), .pin_oe_n_out(pin_oe_n_out), .pull_up_out(pull_up_out),
  .pull_down_out(pull_down_out), .reduced_drive_out(reduced_drive_out),
  .cpu_i_mask_in(cpu_i_mask_in), .port_p_irq_out(port_p_irq_out),
  .port_j_irq_out(port_j_irq_out));

// >>> bench/pig_pad_model.sv
// pad model: resolves each pin from device drive, board drive and pulls
// assumes board drive yields to the device; a floating pin toggles each cycle
`timescale 1ns/1ps
module pig_pad_model (
  // device side
  input wire logic core_clk_in,
  input wire logic [47:0] pin_out,
  input wire logic [47:0] pin_oe_n_out,
  input wire logic [47:0] pull_up_out,
  input wire logic [47:0] pull_down_out,
  // board side
  input wire logic [47:0] ext_val,
  input wire logic [47:0] ext_drive,
  output logic [47:0] pin_level
);
  logic [47:0] float_r = 48'h555555555555;
  always_ff @(posedge core_clk_in) begin
    float_r <= ~float_r;
  end
  assign pin_level = (~pin_oe_n_out & pin_out) | (pin_oe_n_out & ext_drive & ext_val)
    | (pin_oe_n_out & ~ext_drive & (pull_up_out | (~pull_down_out & float_r)));
endmodule

// >>> bench/tb.sv
// self-checking bench of the gpio port block
// assumes ce_in tied high; the pad model stands in for the board
`timescale 1ns/1ps
module tb;
  import pig_pkg::*;
  logic core_clk_in, reset_in, reg_wr_in, reg_rd_in, cpu_i_mask_in;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, v;
  logic [47:0] pin_in, pin_out, pin_oe_n_out, pull_up_out, pull_down_out, reduced_drive_out;
  logic [47:0] periph_own_in, periph_dir_in, periph_data_in, ext_val, ext_drive;
  logic port_p_irq_out, port_j_irq_out, stop_wake_out;
  logic [7:0] pwm_en_in, pwm_data_in, converter_digital_input_enable_in;
  logic [7:0] converter_side_port_data_out;
  logic [47:0] periph_pin_out;
  int bad_count, checked;
  pig_gpio pig_gpio_i (.core_clk_in(core_clk_in), .reset_in(reset_in), .ce_in(1'b1),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n_out(pin_oe_n_out), .pull_up_out(pull_up_out), .pull_down_out(pull_down_out),
    .reduced_drive_out(reduced_drive_out), .periph_own_in(periph_own_in),
    .periph_dir_in(periph_dir_in), .periph_data_in(periph_data_in),
    .periph_pin_out(periph_pin_out), .pwm_en_in(pwm_en_in), .pwm_data_in(pwm_data_in),
    .converter_digital_input_enable_in(converter_digital_input_enable_in),
    .converter_side_port_data_out(converter_side_port_data_out),
    .cpu_i_mask_in(cpu_i_mask_in),
    .port_p_irq_out(port_p_irq_out), .port_j_irq_out(port_j_irq_out),
    .stop_wake_out(stop_wake_out));
  pig_pad_model pig_pad_model_i (.core_clk_in(core_clk_in), .pin_out(pin_out),
    .pin_oe_n_out(pin_oe_n_out), .pull_up_out(pull_up_out), .pull_down_out(pull_down_out),
    .ext_val(ext_val), .ext_drive(ext_drive), .pin_level(pin_in));
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  task automatic stop_test();
    $display("counts: %0d checked, %0d bad", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic t_reset();
    chk(pull_up_out, 48'h0000003f0f00);
    chk(pin_oe_n_out, 48'hffffffffffff);
    rd(8'h0c, v);
    chk(v, 8'h0f);
    rd(8'h14, v);
    chk(v, 8'h3f);
    $display("test reset done");
  endtask
  task automatic t_port_j();
    wr(8'h28, 8'hc0);
    wr(8'h2a, 8'h80);
    cyc(4);
    chk(pin_oe_n_out[47:40], 8'h7f);
    chk(pin_out[47:40], 8'hc0);
    rd(8'h28, v);
    chk(v & 8'hc0, 8'h80);
    rd(8'h29, v);
    chk(v & 8'hc0, 8'h80);
    wr(8'h2b, 8'hc0);
    wr(8'h2c, 8'hc0);
    cyc(2);
    chk(reduced_drive_out[47:40], 8'h80);
    chk(pull_up_out[47:40], 8'h40);
    wr(8'h2d, 8'hc0);
    cyc(2);
    chk(pull_down_out[47:40], 8'h40);
    rd(8'h2b, v);
    chk(v, 8'hc0);
    $display("test port j done");
  endtask
  task automatic t_periph();
    @(posedge core_clk_in);
    periph_own_in[46] <= 1'b1;
    periph_dir_in[46] <= 1'b1;
    periph_data_in[46] <= 1'b1;
    cyc(3);
    chk({pin_oe_n_out[46], pin_out[46]}, 2'b01);
    @(posedge core_clk_in);
    periph_own_in[46] <= 1'b0;
    $display("test peripheral done");
  endtask
  task automatic t_edge();
    wr(8'h1e, 8'h01);
    wr(8'h1d, 8'h01);
    cyc(4);
    chk(port_p_irq_out, 1'b0);
    @(posedge core_clk_in);
    ext_val[24] <= 1'b1;
    cyc(5);
    chk(port_p_irq_out, 1'b1);
    @(posedge core_clk_in);
    cpu_i_mask_in <= 1'b1;
    cyc(1);
    chk(port_p_irq_out, 1'b0);
    @(posedge core_clk_in);
    cpu_i_mask_in <= 1'b0;
    cyc(1);
    chk(port_p_irq_out, 1'b1);
    rd(8'h19, v);
    chk(v, 8'h01);
    rd(8'h1f, v);
    chk(v, 8'h01);
    wr(8'h1f, 8'h01);
    cyc(2);
    rd(8'h1f, v);
    chk(v, 8'h00);
    chk(port_p_irq_out, 1'b0);
    rd(8'h31, v);
    chk(v, 8'h00);
    $display("test edge done");
  endtask
  task automatic t_route();
    wr(8'h30, 8'h01);
    rd(8'h30, v);
    chk(v, 8'h01);
    @(posedge core_clk_in);
    pwm_en_in <= 8'h01;
    pwm_data_in <= 8'h01;
    cyc(2);
    chk({pin_oe_n_out[24], pin_oe_n_out[0], pin_out[0]}, 3'b101);
    wr(8'h30, 8'h00);
    cyc(2);
    chk({pin_oe_n_out[24], pin_out[24], pin_oe_n_out[0]}, 3'b011);
    @(posedge core_clk_in);
    pwm_en_in <= 8'h00;
    $display("test route done");
  endtask
  task automatic t_analog();
    @(posedge core_clk_in);
    ext_drive[39:32] <= 8'hff;
    ext_val[39:32] <= 8'ha5;
    converter_digital_input_enable_in <= 8'h0f;
    cyc(4);
    chk(periph_pin_out[39:32], 8'ha5);
    chk(converter_side_port_data_out, 8'h05);
    wr(8'h22, 8'h01);
    cyc(2);
    chk(pin_oe_n_out[32], 1'b0);
    chk(converter_side_port_data_out, 8'h04);
    $display("test analog done");
  endtask
  task automatic t_wake();
    wr(8'h2f, 8'hc0);
    wr(8'h2e, 8'h40);
    cyc(4);
    chk(port_j_irq_out, 1'b0);
    @(posedge core_clk_in);
    ext_val[46] <= 1'b1;
    #1 chk(stop_wake_out, 1'b1);
    cyc(4);
    chk({port_j_irq_out, stop_wake_out}, 2'b10);
    $display("test wake done");
  endtask
  task automatic t_wired();
    wr(8'h0e, 8'h01);
    wr(8'h0a, 8'h01);
    cyc(2);
    chk({pin_oe_n_out[8], pull_up_out[8]}, 2'b01);
    wr(8'h0d, 8'h01);
    cyc(2);
    chk({pull_up_out[8], pull_down_out[8]}, 2'b10);
    wr(8'h08, 8'h01);
    cyc(2);
    chk({pin_oe_n_out[8], pull_up_out[8]}, 2'b11);
    $display("test wired-or done");
  endtask
  task automatic t_rerun();
    @(posedge core_clk_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    reset_in <= 1'b0;
    cyc(1);
    t_reset();
    rd(8'h2a, v);
    chk(v, 8'h00);
    $display("test mid-run reset done");
  endtask
  initial begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end
  initial begin
    repeat (20000) @(posedge core_clk_in);
    bad_count++;
    $display("MISMATCH at %0t: timeout", $time);
    stop_test();
  end
  initial begin
    {reg_wr_in, reg_rd_in, cpu_i_mask_in, reg_addr_in, reg_wdata_in} = '0;
    {periph_own_in, periph_dir_in, periph_data_in, ext_val} = '0;
    {pwm_en_in, pwm_data_in, converter_digital_input_enable_in} = '0;
    ext_drive = 48'hc000ff000000;
    reset_in = 1'b1;
    repeat (20) @(posedge core_clk_in);
    reset_in <= 1'b0;
    cyc(1);
    t_reset();
    t_port_j();
    t_periph();
    t_edge();
    t_route();
    t_analog();
    t_wake();
    t_wired();
    t_rerun();
    stop_test();
  end
endmodule
